// *** hdl/pbus_port.sv ***
// Console end of the peripheral port: byte-wide memory bus and bit-serial I/O bus.
// Assumes a requester on core_clk and port pins timed by link_clk, unrelated in phase.
// Operation
// - Select peripheral window at 4000 hex
// - Leave A000 to FFFF free for expansion
// - Voice select at 9000/9400 after address valid
// - Bit space split internal, reserved, port
// - Port interrupt feeds a maskable input
// - Word read as two assembled bytes
// - Read: strobe low, direction high, write high
// - Address with strobe, 100 ns settling
// - Peripheral select at phase two, cycle one
// - Sample data in cycle five, 100 ns setup
// - One internal cycle before every memory write
// - Write enable low 660 ns from phase two
// - Odd byte first, even byte second
// - Low address switches at 970 ns, repeat write
// - Peripheral select low whole two-byte write
// - Bit output two cycles, address settles
// - Short low strobe after phase one, cycle two
// - Output bit valid from transfer start
// - Bit input sampled at cycle two start
`timescale 1ns/1ps
`default_nettype none

module pbus_port
	import pbus_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        link_clk,
	input  wire logic        req_valid,
	input  wire pbus_req_t   req,
	output var  logic        req_ready,
	output var  logic        rsp_valid,
	output var  pbus_rsp_t   rsp,
	input  wire logic        int_mask,
	output var  logic        maskable_int,
	input  wire logic        port_interrupt_n,
	output var  logic [14:0] port_addr,
	output var  logic        a15_bitout_shared,
	output var  logic        mem_cycle_strobe_n,
	output var  logic        bus_read_direction,
	output var  logic        write_enable_n,
	output var  logic        periph_block_select_n,
	output var  logic        voice_block_select_n,
	output var  logic [7:0]  port_data_o,
	output var  logic        port_data_oe,
	input  wire logic [7:0]  port_data_i,
	output var  logic        bit_io_strobe_n,
	input  wire logic        bit_io_in,
	output var  logic        phase_one,
	output var  logic        phase_two
);

	// Tick compare: true in the cycle before the counter reaches t
	function automatic logic at_tick(input logic [TICK_W-1:0] c, input int t);
		return c == TICK_W'(t - 1);
	endfunction

	// ---------------- core domain ----------------
	logic        pint_s1_reg, pint_s2_reg;
	logic        int_reg;
	logic        busy_reg;
	logic        ready_reg;
	pbus_req_t   creq_reg;
	logic        req_tgl_reg;
	logic        done_s1_reg, done_s2_reg, done_s3_reg;
	logic        rsp_valid_reg;
	pbus_rsp_t   rsp_reg;
	logic        done_tgl_reg;
	pbus_rsp_t   lrsp_reg;

	// Request admission and bit space range check
	wire logic accept    = req_valid & ready_reg;
	wire logic bit_ok    = (req.addr >= BITIO_PORT_LO) && (req.addr <= BITIO_PORT_HI);
	wire logic refuse    = accept & req.bitio & ~bit_ok;
	wire logic launch    = accept & ~refuse;
	wire logic done_edge = done_s2_reg ^ done_s3_reg;

	// Port interrupt enters through two flops, then is gated by the mask
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pint_s1_reg <= 1'b0;
			pint_s2_reg <= 1'b0;
			int_reg     <= 1'b0;
		end else begin
			pint_s1_reg <= ~port_interrupt_n;
			pint_s2_reg <= pint_s1_reg;
			int_reg     <= pint_s2_reg & ~int_mask;
		end
	end

	// Request hand-off: word held stable while a toggle crosses to the link
	always_ff @(posedge core_clk) begin
		if (reset) begin
			busy_reg    <= 1'b0;
			ready_reg   <= 1'b0;
			creq_reg    <= '0;
			req_tgl_reg <= 1'b0;
		end else begin
			ready_reg <= ~busy_reg & ~launch & ~refuse;
			if (launch) begin
				busy_reg    <= 1'b1;
				creq_reg    <= req;
				req_tgl_reg <= ~req_tgl_reg;
			end else if (done_edge) begin
				busy_reg  <= 1'b0;
				ready_reg <= 1'b1;
			end
		end
	end

	// Completion toggle from the link, three stages for a clean edge
	always_ff @(posedge core_clk) begin
		if (reset) begin
			done_s1_reg <= 1'b0;
			done_s2_reg <= 1'b0;
			done_s3_reg <= 1'b0;
		end else begin
			done_s1_reg <= done_tgl_reg;
			done_s2_reg <= done_s1_reg;
			done_s3_reg <= done_s2_reg;
		end
	end

	// Answer: one-cycle pulse with the link result or an immediate refusal
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rsp_valid_reg <= 1'b0;
			rsp_reg       <= '0;
		end else begin
			rsp_valid_reg <= done_edge | refuse;
			if (refuse) begin
				rsp_reg <= '{rdata: '0, err: 1'b1};
			end else if (done_edge) begin
				rsp_reg <= lrsp_reg;
			end
		end
	end

	assign req_ready    = ready_reg;
	assign rsp_valid    = rsp_valid_reg;
	assign rsp          = rsp_reg;
	assign maskable_int = int_reg;

	// ---------------- link domain ----------------
	logic                lrst_s1_reg, lrst_s2_reg;
	logic                rq_s1_reg, rq_s2_reg, rq_s3_reg;
	logic [7:0]          din_s1_reg, din_s2_reg;
	logic                bin_s1_reg, bin_s2_reg;
	pbus_lstate_t        state_reg, state_next;
	logic [TICK_W-1:0]   cnt_reg, cnt_next;
	logic                byte_idx_reg, byte_idx_next;
	logic [TICK_W-1:0]   ph_cnt_reg;
	logic                ph1_reg, ph2_reg;
	logic [14:0]         addr_reg, addr_next;
	logic                a15_reg, a15_next;
	logic                strobe_n_reg, strobe_n_next;
	logic                dir_reg, dir_next;
	logic                we_n_reg, we_n_next;
	logic                psel_n_reg, psel_n_next;
	logic                vsel_n_reg, vsel_n_next;
	logic [7:0]          dout_reg, dout_next;
	logic                doe_reg, doe_next;
	logic                bstb_n_reg, bstb_n_next;
	logic                done_next;
	pbus_rsp_t           lrsp_next;

	// Request seen on the link; the held core word is stable by now
	wire logic      req_edge  = rq_s2_reg ^ rq_s3_reg;
	wire pbus_req_t lreq      = creq_reg;
	wire logic      idle      = state_reg == LS_IDLE;
	// Window decode; nothing is selected at or above the expansion base
	wire logic      periph_hit = (lreq.addr & PERIPH_MASK) == PERIPH_BASE;
	wire logic      voice_hit  = ((lreq.addr & VOICE_MASK) == VOICE_WR_LO) ||
	                            ((lreq.addr & VOICE_MASK) == VOICE_WR_HI);
	wire logic      start_rd  = idle & req_edge & ~lreq.bitio & ~lreq.write;
	wire logic      alu_done  = (state_reg == LS_ALU) & at_tick(cnt_reg, ALU_TICKS);
	wire logic      go_mem    = start_rd | alu_done;
	wire logic      byte_end  = (state_reg == LS_BYTE) & at_tick(cnt_reg, BYTE_TICKS);
	wire logic      last_byte = byte_end & byte_idx_reg;
	wire logic      bit_end   = (state_reg == LS_BIT) & at_tick(cnt_reg, BIT_END_TICKS);
	wire logic      finish    = last_byte | bit_end;

	// Reset and pin inputs pass two flops before use
	always_ff @(posedge link_clk) begin
		lrst_s1_reg <= reset;
		lrst_s2_reg <= lrst_s1_reg;
		din_s1_reg  <= port_data_i;
		din_s2_reg  <= din_s1_reg;
		bin_s1_reg  <= bit_io_in;
		bin_s2_reg  <= bin_s1_reg;
	end

	// Request toggle crossing from the core
	always_ff @(posedge link_clk) begin
		if (lrst_s2_reg) begin
			rq_s1_reg <= 1'b0;
			rq_s2_reg <= 1'b0;
			rq_s3_reg <= 1'b0;
		end else begin
			rq_s1_reg <= req_tgl_reg;
			rq_s2_reg <= rq_s1_reg;
			rq_s3_reg <= rq_s2_reg;
		end
	end

	// Transfer sequencer next state and pin values
	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg + TICK_W'(1);
		byte_idx_next = byte_idx_reg;
		addr_next     = addr_reg;
		a15_next      = a15_reg;
		strobe_n_next = strobe_n_reg;
		dir_next      = dir_reg;
		we_n_next     = we_n_reg;
		psel_n_next   = psel_n_reg;
		vsel_n_next   = vsel_n_reg;
		dout_next     = dout_reg;
		doe_next      = doe_reg;
		bstb_n_next   = bstb_n_reg;
		done_next     = done_tgl_reg;
		lrsp_next     = lrsp_reg;
		case (state_reg)
			LS_IDLE: begin
				cnt_next = '0;
				if (req_edge & lreq.bitio) begin
					state_next = LS_BIT;
					addr_next  = lreq.addr[15:1];
					a15_next   = lreq.wdata[0];
				end else if (req_edge & lreq.write) begin
					state_next = LS_ALU;
				end
			end
			LS_ALU: begin
			end
			LS_BYTE: begin
				if (at_tick(cnt_reg, SELECT_TICKS)) begin
					psel_n_next = ~periph_hit;
					vsel_n_next = ~voice_hit;
				end
				if (lreq.write & at_tick(cnt_reg, WE_START_TICKS)) begin
					we_n_next = 1'b0;
				end
				if (lreq.write & at_tick(cnt_reg, WE_END_TICKS)) begin
					we_n_next = 1'b1;
				end
				if (~lreq.write & at_tick(cnt_reg, SAMPLE_TICKS)) begin
					if (byte_idx_reg) begin
						lrsp_next.rdata[15:8] = din_s2_reg;
					end else begin
						lrsp_next.rdata[7:0] = din_s2_reg;
					end
				end
				if (byte_end & ~byte_idx_reg) begin
					cnt_next      = '0;
					byte_idx_next = 1'b1;
					a15_next      = 1'b0;
					dout_next     = lreq.wdata[15:8];
				end
			end
			LS_BIT: begin
				if (at_tick(cnt_reg, BIT_SAMPLE_TICKS)) begin
					lrsp_next.rdata = {15'h0000, bin_s2_reg};
				end
				if (lreq.write & at_tick(cnt_reg, BIT_STB_TICKS)) begin
					bstb_n_next = 1'b0;
				end
				if (at_tick(cnt_reg, BIT_STB_END_TICKS)) begin
					bstb_n_next = 1'b1;
				end
			end
			default: begin
				state_next = LS_IDLE;
			end
		endcase
		// Byte cycle start: address, strobe and direction together
		if (go_mem) begin
			state_next    = LS_BYTE;
			cnt_next      = '0;
			byte_idx_next = 1'b0;
			addr_next     = lreq.addr[15:1];
			a15_next      = 1'b1;
			strobe_n_next = 1'b0;
			dir_next      = ~lreq.write;
			we_n_next     = 1'b1;
			doe_next      = lreq.write;
			dout_next     = lreq.wdata[7:0];
			lrsp_next     = '0;
		end
		// End of transfer: release the bus and signal completion
		if (finish) begin
			state_next    = LS_IDLE;
			cnt_next      = '0;
			strobe_n_next = 1'b1;
			dir_next      = 1'b0;
			we_n_next     = 1'b1;
			psel_n_next   = 1'b1;
			vsel_n_next   = 1'b1;
			doe_next      = 1'b0;
			bstb_n_next   = 1'b1;
			lrsp_next.err = 1'b0;
			done_next     = ~done_tgl_reg;
		end
	end

	// Sequencer state
	always_ff @(posedge link_clk) begin
		if (lrst_s2_reg) begin
			state_reg    <= LS_IDLE;
			cnt_reg      <= '0;
			byte_idx_reg <= 1'b0;
			done_tgl_reg <= 1'b0;
			lrsp_reg     <= '0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			byte_idx_reg <= byte_idx_next;
			done_tgl_reg <= done_next;
			lrsp_reg     <= lrsp_next;
		end
	end

	// Port pin registers
	always_ff @(posedge link_clk) begin
		if (lrst_s2_reg) begin
			addr_reg     <= '0;
			a15_reg      <= 1'b0;
			strobe_n_reg <= 1'b1;
			dir_reg      <= 1'b0;
			we_n_reg     <= 1'b1;
			psel_n_reg   <= 1'b1;
			vsel_n_reg   <= 1'b1;
			dout_reg     <= '0;
			doe_reg      <= 1'b0;
			bstb_n_reg   <= 1'b1;
		end else begin
			addr_reg     <= addr_next;
			a15_reg      <= a15_next;
			strobe_n_reg <= strobe_n_next;
			dir_reg      <= dir_next;
			we_n_reg     <= we_n_next;
			psel_n_reg   <= psel_n_next;
			vsel_n_reg   <= vsel_n_next;
			dout_reg     <= dout_next;
			doe_reg      <= doe_next;
			bstb_n_reg   <= bstb_n_next;
		end
	end

	// Two-phase clock outputs, restarted with each transfer, quiet when idle
	always_ff @(posedge link_clk) begin
		if (lrst_s2_reg || (idle && !req_edge)) begin
			ph_cnt_reg <= '0;
			ph1_reg    <= 1'b0;
			ph2_reg    <= 1'b0;
		end else if (idle || finish) begin
			ph_cnt_reg <= '0;
			ph1_reg    <= ~finish;
			ph2_reg    <= 1'b0;
		end else if (at_tick(ph_cnt_reg, PHASE_TICKS)) begin
			ph_cnt_reg <= '0;
			ph1_reg    <= ~ph1_reg;
			ph2_reg    <= ph1_reg;
		end else begin
			ph_cnt_reg <= ph_cnt_reg + TICK_W'(1);
		end
	end

	assign port_addr             = addr_reg;
	assign a15_bitout_shared     = a15_reg;
	assign mem_cycle_strobe_n    = strobe_n_reg;
	assign bus_read_direction    = dir_reg;
	assign write_enable_n        = we_n_reg;
	assign periph_block_select_n = psel_n_reg;
	assign voice_block_select_n  = vsel_n_reg;
	assign port_data_o           = dout_reg;
	assign port_data_oe          = doe_reg;
	assign bit_io_strobe_n       = bstb_n_reg;
	assign phase_one             = ph1_reg;
	assign phase_two             = ph2_reg;

endmodule

`default_nettype wire

// *** hdl/pbus_pkg.sv ***
// Shared constants, carrier types and link states of the peripheral port bus engine.
// Assumes a 15 ns link clock for the port pins and a 100 MHz core clock for the requester.
package pbus_pkg;

	// Link clock period that every port timing count is built on
	localparam int LINK_CLK_NS      = 15;
	localparam int TICK_W           = 8;

	// Port timing in nanoseconds, measured from the start of a byte or bit transfer
	localparam int CPU_CYCLE_NS     = 200;  // One processor clock cycle
	localparam int PHASE_NS         = 100;  // Each of the two phases of a cycle
	localparam int ADDR_SETTLE_NS   = 100;  // Least address settling before any select
	localparam int READ_VALID_NS    = 750;  // Latest point at which the card drives read data
	localparam int READ_MARGIN_NS   = 100;  // Data set-up before the processor sample
	localparam int WE_START_NS      = 300;  // Phase two of the wait state cycle
	localparam int WE_LOW_NS        = 660;
	localparam int BYTE_SWITCH_NS   = 970;  // Low address line turns to the second byte
	localparam int BIT_SAMPLE_NS    = 200;  // Phase one of cycle two
	localparam int BIT_STROBE_AT_NS = 300;  // Trailing edge of phase one of cycle two
	localparam int BIT_STROBE_NS    = 80;
	localparam int BIT_XFER_NS      = 400;  // Two processor cycles

	// Least time as whole link ticks, never below one
	function automatic int pbus_ticks(input int ns);
		int t;
		t = (ns + LINK_CLK_NS - 1) / LINK_CLK_NS;
		return (t < 1) ? 1 : t;
	endfunction

	localparam int ALU_TICKS        = pbus_ticks(CPU_CYCLE_NS);
	localparam int PHASE_TICKS      = pbus_ticks(PHASE_NS);
	localparam int SELECT_TICKS     = pbus_ticks(ADDR_SETTLE_NS);
	localparam int SAMPLE_TICKS     = pbus_ticks(READ_VALID_NS + READ_MARGIN_NS);
	localparam int WE_START_TICKS   = pbus_ticks(WE_START_NS);
	localparam int WE_END_TICKS     = WE_START_TICKS + pbus_ticks(WE_LOW_NS);
	localparam int BYTE_TICKS       = pbus_ticks(BYTE_SWITCH_NS);
	localparam int BIT_SAMPLE_TICKS = pbus_ticks(BIT_SAMPLE_NS);
	localparam int BIT_STB_TICKS    = pbus_ticks(BIT_STROBE_AT_NS);
	localparam int BIT_STB_END_TICKS = BIT_STB_TICKS + pbus_ticks(BIT_STROBE_NS);
	localparam int BIT_END_TICKS    = pbus_ticks(BIT_XFER_NS);

	// Memory map of the port
	localparam logic [15:0] PERIPH_BASE  = 16'h4000;
	localparam logic [15:0] PERIPH_MASK  = 16'hE000;
	localparam logic [15:0] VOICE_MASK   = 16'hFC00;
	localparam logic [15:0] VOICE_WR_LO  = 16'h9000;
	localparam logic [15:0] VOICE_WR_HI  = 16'h9400;
	localparam logic [15:0] EXPAND_BASE  = 16'hA000;

	// Bit-serial I/O space split
	localparam logic [15:0] BITIO_INT_TOP  = 16'h07FE;
	localparam logic [15:0] BITIO_PORT_LO  = 16'h1000;
	localparam logic [15:0] BITIO_PORT_HI  = 16'h1FFE;

	// Request from the processor side; a bit transfer carries its output bit in wdata[0]
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        write;
		logic        bitio;
	} pbus_req_t;

	// Answer; a bit input comes back in rdata[0]
	typedef struct packed {
		logic [15:0] rdata;
		logic        err;
	} pbus_rsp_t;

	typedef enum logic [1:0] {
		LS_IDLE,
		LS_ALU,
		LS_BYTE,
		LS_BIT
	} pbus_lstate_t;

endpackage

// *** verification/pbus_port_properties.sv ***
// Checker for the port engine: pin timing and address decode relations.
// Bound to pbus_port; sees its ports only, link rules clocked by link_clk.
`timescale 1ns/1ps
`default_nettype none
module pbus_port_props
	import pbus_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        link_clk,
	input wire logic        req_valid,
	input wire pbus_req_t   req,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire pbus_rsp_t   rsp,
	input wire logic        int_mask,
	input wire logic        maskable_int,
	input wire logic        port_interrupt_n,
	input wire logic [14:0] port_addr,
	input wire logic        a15_bitout_shared,
	input wire logic        mem_cycle_strobe_n,
	input wire logic        bus_read_direction,
	input wire logic        write_enable_n,
	input wire logic        periph_block_select_n,
	input wire logic        voice_block_select_n,
	input wire logic        port_data_oe,
	input wire logic        bit_io_strobe_n,
	input wire logic        phase_one,
	input wire logic        phase_two
);
	localparam int WE_LOW_T = WE_END_TICKS - WE_START_TICKS;
	logic [7:0] we_cnt_reg;
	// Counts link ticks with write enable low
	always_ff @(posedge link_clk) begin
		we_cnt_reg <= write_enable_n ? 8'h00 : we_cnt_reg + 8'h01;
	end
	property p_read_we;
		@(posedge link_clk) disable iff (reset)
		!mem_cycle_strobe_n && bus_read_direction |-> write_enable_n;
	endproperty
	a_read_we: assert property (p_read_we) else $error("write enable low in read");
	property p_periph_dec;
		@(posedge link_clk) disable iff (reset)
		!periph_block_select_n |-> port_addr[14:12] == 3'b010;
	endproperty
	a_periph_dec: assert property (p_periph_dec) else $error("select outside window");
	property p_expand;
		@(posedge link_clk) disable iff (reset)
		!mem_cycle_strobe_n && port_addr[14:12] >= 3'b101
		|-> periph_block_select_n && voice_block_select_n;
	endproperty
	a_expand: assert property (p_expand) else $error("select in expansion");
	property p_voice_dec;
		@(posedge link_clk) disable iff (reset)
		!voice_block_select_n |-> port_addr[14:10] == 5'b10010;
	endproperty
	a_voice_dec: assert property (p_voice_dec) else $error("voice select misdecoded");
	property p_sel_time;
		@(posedge link_clk) disable iff (reset)
		$fell(mem_cycle_strobe_n) && port_addr[14:12] == 3'b010
		|-> periph_block_select_n[*6] ##[1:2] !periph_block_select_n;
	endproperty
	a_sel_time: assert property (p_sel_time) else $error("select timing");
	property p_sel_phase;
		@(posedge link_clk) disable iff (reset)
		$fell(periph_block_select_n) |-> $rose(phase_two) && !phase_one;
	endproperty
	a_sel_phase: assert property (p_sel_phase) else $error("select off phase two");
	property p_odd_first;
		@(posedge link_clk) disable iff (reset)
		$fell(mem_cycle_strobe_n) |-> a15_bitout_shared;
	endproperty
	a_odd_first: assert property (p_odd_first) else $error("even byte first");
	property p_we_len;
		@(posedge link_clk) disable iff (reset)
		$rose(write_enable_n) |-> int'(we_cnt_reg) == WE_LOW_T;
	endproperty
	a_we_len: assert property (p_we_len) else $error("write enable width");
	property p_sel_hold;
		@(posedge link_clk) disable iff (reset)
		$fell(a15_bitout_shared) && port_data_oe && port_addr[14:12] == 3'b010
		|-> !periph_block_select_n;
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select dropped in write");
	property p_bit_stb;
		@(posedge link_clk) disable iff (reset)
		$fell(bit_io_strobe_n)
		|-> (!bit_io_strobe_n && mem_cycle_strobe_n)[*6] ##1 bit_io_strobe_n;
	endproperty
	a_bit_stb: assert property (p_bit_stb) else $error("bit strobe width");
	property p_refuse;
		@(posedge core_clk) disable iff (reset)
		req_valid && req_ready && req.bitio
		&& (req.addr < BITIO_PORT_LO || req.addr > BITIO_PORT_HI)
		|-> ##[1:3] (rsp_valid && rsp.err);
	endproperty
	a_refuse: assert property (p_refuse) else $error("bit address not refused");
	property p_int;
		@(posedge core_clk) disable iff (reset)
		(!port_interrupt_n && !int_mask)[*5] |-> maskable_int;
	endproperty
	a_int: assert property (p_int) else $error("interrupt not passed");
	property p_int_mask;
		@(posedge core_clk) disable iff (reset)
		int_mask[*2] |-> !maskable_int;
	endproperty
	a_int_mask: assert property (p_int_mask) else $error("interrupt not masked");
endmodule
bind pbus_port pbus_port_props i_props (.core_clk, .reset, .link_clk, .req_valid, .req,
	.req_ready, .rsp_valid, .rsp, .int_mask, .maskable_int, .port_interrupt_n, .port_addr,
	.a15_bitout_shared, .mem_cycle_strobe_n, .bus_read_direction, .write_enable_n,
	.periph_block_select_n, .voice_block_select_n, .port_data_oe, .bit_io_strobe_n,
	.phase_one, .phase_two);
`default_nettype wire

// *** verification/pbus_card_model.sv ***
// Plug-in card model: byte memory behind the selects and a 128-bit bit block.
// Assumes the port pins of pbus_port; released lines toggle every link tick.
`timescale 1ns/1ps
`default_nettype none
module pbus_card_model
	import pbus_pkg::*;
#(
	parameter logic [7:0] CARD_BLOCK = 8'h11,
	parameter logic [3:0] ROM_PAGE   = 4'hB
)
(
	input  wire logic        link_clk,
	input  wire logic [14:0] port_addr,
	input  wire logic        a15_bitout_shared,
	input  wire logic        mem_cycle_strobe_n,
	input  wire logic        bus_read_direction,
	input  wire logic        write_enable_n,
	input  wire logic        periph_block_select_n,
	input  wire logic        voice_block_select_n,
	input  wire logic [7:0]  port_data_o,
	input  wire logic        bit_io_strobe_n,
	output wire logic [7:0]  port_data_i,
	output wire logic        bit_io_in
);
	logic [7:0] mem [0:8191];
	logic       bits [0:127];
	logic       tog = 1'b0;
	wire [12:0] midx = {port_addr[11:0], a15_bitout_shared};
	// Own ROM page decoded on the card, the console gives no select for it
	wire        rom_hit = !mem_cycle_strobe_n && port_addr[14:11] == ROM_PAGE;
	wire        cs = !periph_block_select_n || !voice_block_select_n || rom_hit;
	wire        rd_drv = cs && !mem_cycle_strobe_n && bus_read_direction;
	wire        inblk = port_addr[14:7] == CARD_BLOCK;
	// Fill memory and bits with a known pattern
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 8'(i * 7 + 3);
			if (i < 128) bits[i] = i[0];
		end
	end
	always @(posedge link_clk) tog <= ~tog;
	// Data only while selected for a read, else a changing pattern
	assign port_data_i = rd_drv ? mem[midx] : {8{tog}};
	// Bit answered only inside the own block
	assign bit_io_in = inblk ? bits[port_addr[6:0]] : tog;
	// Byte stored as write enable ends
	always @(posedge write_enable_n) begin
		if (cs === 1'b1) mem[midx] <= port_data_o;
	end
	// Output bit latched by the strobe, own block only
	always @(posedge bit_io_strobe_n) begin
		if (inblk === 1'b1) bits[port_addr[6:0]] <= a15_bitout_shared;
	end
endmodule
`default_nettype wire

// *** verification/peripheral_io_port_bus_tb_top.sv ***
// Testbench: word, voice, expansion, bit and interrupt traffic on pbus_port.
// Assumes the card model on the pins and a byte and bit model kept here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module peripheral_io_port_bus_tb_top
	import pbus_pkg::*;
;
	logic core_clk, link_clk, reset, req_valid, req_ready, rsp_valid;
	logic int_mask, maskable_int, port_interrupt_n, a15_bitout_shared;
	logic mem_cycle_strobe_n, bus_read_direction, write_enable_n, port_data_oe;
	logic periph_block_select_n, voice_block_select_n, bit_io_strobe_n, bit_io_in;
	logic phase_one, phase_two;
	logic [14:0] port_addr;
	logic [7:0] port_data_o, port_data_i;
	pbus_req_t req;
	pbus_rsp_t rsp, got;
	int n_errors, checks_done, seed;
	logic [7:0] mm [int];
	logic bm [int];
	logic [15:0] a, d;
	logic v;
	pbus_port i_pbus_port (.core_clk, .reset, .link_clk, .req_valid, .req, .req_ready,
		.rsp_valid, .rsp, .int_mask, .maskable_int, .port_interrupt_n, .port_addr,
		.a15_bitout_shared, .mem_cycle_strobe_n, .bus_read_direction, .write_enable_n,
		.periph_block_select_n, .voice_block_select_n, .port_data_o, .port_data_oe,
		.port_data_i, .bit_io_strobe_n, .bit_io_in, .phase_one, .phase_two);
	pbus_card_model i_pbus_card_model (.link_clk, .port_addr, .a15_bitout_shared,
		.mem_cycle_strobe_n, .bus_read_direction, .write_enable_n, .periph_block_select_n,
		.voice_block_select_n, .port_data_o, .bit_io_strobe_n, .port_data_i, .bit_io_in);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Link clock with an unrelated phase
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	function automatic logic [7:0] mrd(int i);
		return mm.exists(i) ? mm[i] : 8'(i * 7 + 3);
	endfunction
	function automatic logic brd(int i);
		return bm.exists(i) ? bm[i] : i[0];
	endfunction
	// One request, held until taken, then wait for the answer
	task automatic xfer(input logic [15:0] ad, input logic [15:0] wd, input logic w, b);
		int n;
		@(posedge core_clk);
		#1;
		req_valid = 1'b1;
		req = '{addr: ad, wdata: wd, write: w, bitio: b};
		n = 0;
		// Ready is looked at where it is settled; the next edge takes the request
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		@(posedge core_clk);
		#1;
		req_valid = 1'b0;
		if (n >= 50) begin
			n_errors++;
			$display("Error at %0t: request not taken", $time);
		end
		n = 0;
		while (rsp_valid !== 1'b1 && n < 1000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 1000) begin
			n_errors++;
			$display("Error at %0t: no answer", $time);
		end
		got = rsp;
	endtask
	task automatic wr_word(input logic [15:0] ad, input logic [15:0] wd);
		xfer(ad, wd, 1'b1, 1'b0);
		mm[int'({ad[12:1], 1'b1})] = wd[7:0];
		mm[int'({ad[12:1], 1'b0})] = wd[15:8];
	endtask
	task automatic rd_word(input logic [15:0] ad);
		int i;
		i = int'({ad[12:1], 1'b0});
		xfer(ad, 16'h0000, 1'b0, 1'b0);
		`CHK(got.rdata, {mrd(i), mrd(i + 1)})
	endtask
	task automatic bit_wr(input logic [15:0] ad, input logic bv);
		xfer(ad, {15'h0000, bv}, 1'b1, 1'b1);
		`CHK(got.err, 1'b0)
		if (ad[15:8] == 8'h11) bm[int'(ad[7:1])] = bv;
	endtask
	task automatic bit_rd(input logic [15:0] ad);
		logic e;
		e = brd(int'(ad[7:1]));
		xfer(ad, {15'h0000, ~e}, 1'b0, 1'b1);
		`CHK(got.rdata[0], e)
	endtask
	task automatic end_sim;
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well beyond the expected run time
	initial begin
		#500_000;
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		end_sim;
	end
	initial begin
		seed = 76850;
		n_errors = 0;
		checks_done = 0;
		reset = 1'b1;
		req_valid = 1'b0;
		req = '0;
		int_mask = 1'b1;
		port_interrupt_n = 1'b1;
		repeat (20) @(posedge core_clk);
		#1 reset = 1'b0;
		// Random words in the peripheral window, neighbour read too
		repeat (4) begin
			a = 16'h4000 | (16'($random(seed)) & 16'h0FFE);
			d = 16'($random(seed));
			wr_word(a, d);
			rd_word(a);
			rd_word(a ^ 16'h0002);
		end
		$display("Test window words done");
		// Voice area, both halves
		rd_word(16'h9000);
		wr_word(16'h9400, 16'($random(seed)));
		rd_word(16'h9400);
		$display("Test voice done");
		// Expansion area: decode watched on the pins
		xfer(16'hA000, 16'h0000, 1'b0, 1'b0);
		`CHK(got.err, 1'b0)
		xfer(16'hC002, 16'h1234, 1'b1, 1'b0);
		`CHK(got.err, 1'b0)
		rd_word(16'hB000);
		$display("Test expansion done");
		// Bits in the card block, then a write to a foreign block
		for (int k = 0; k < 8; k++) begin
			v = 1'($random(seed));
			bit_wr(16'h1100 + 16'(2 * k), v);
			bit_rd(16'h1100 + 16'(2 * k));
		end
		bit_wr(16'h1200, ~brd(0));
		bit_rd(16'h1100);
		for (int j = 0; j < 4; j++) begin
			a = (j == 0) ? 16'h0100 : (j == 1) ? 16'h0800 : (j == 2) ? 16'h0FFE : 16'h2000;
			xfer(a, 16'h0001, j[0], 1'b1);
			`CHK(got.err, 1'b1)
			`CHK(got.rdata, 16'h0000)
		end
		$display("Test bits done");
		// Interrupt passed, masked, unmasked, released
		@(posedge core_clk);
		#1 int_mask = 1'b0;
		port_interrupt_n = 1'b0;
		repeat (8) @(posedge core_clk);
		`CHK(maskable_int, 1'b1)
		#1 int_mask = 1'b1;
		repeat (4) @(posedge core_clk);
		`CHK(maskable_int, 1'b0)
		#1 int_mask = 1'b0;
		repeat (4) @(posedge core_clk);
		`CHK(maskable_int, 1'b1)
		#1 port_interrupt_n = 1'b1;
		repeat (8) @(posedge core_clk);
		`CHK(maskable_int, 1'b0)
		$display("Test interrupt done");
		end_sim;
	end
endmodule
`default_nettype wire
